// ==== ptmr_pkg.sv ====
package ptmr_pkg;
	localparam int unsigned ADDR_W          = 12;
	localparam logic [11:0] OFS_CONTROL     = 12'h000;
	localparam logic [11:0] OFS_COUNT       = 12'h004;
	localparam logic [11:0] OFS_PERIOD      = 12'h008;
	localparam logic [11:0] OFS_FLAG        = 12'h00c;
	localparam logic [11:0] OFS_ENABLE      = 12'h010;
	localparam int unsigned CTL_RUN_BIT     = 2;
	localparam int unsigned CTL_PS_LO       = 0;
	localparam int unsigned CTL_POST_LO     = 3;
	localparam logic [7:0]  CTL_IMPL_MASK   = 8'h7f;
	localparam logic [7:0]  CONTROL_RESET   = 8'h00;
	localparam logic [7:0]  COUNT_RESET     = 8'h00;
	localparam logic [7:0]  PERIOD_RESET    = 8'hff;
	localparam logic [1:0]  PS_DIV1         = 2'h0;
	localparam logic [1:0]  PS_DIV4         = 2'h1;
	localparam logic [1:0]  PS_DIV16        = 2'h2;
	localparam logic [5:0]  PS_LAST_DIV1    = 6'h00;
	localparam logic [5:0]  PS_LAST_DIV4    = 6'h03;
	localparam logic [5:0]  PS_LAST_DIV16   = 6'h0f;
	localparam logic [5:0]  PS_LAST_DIV64   = 6'h3f;
	localparam logic [1:0]  INSTR_DIV_LAST  = 2'h3;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;
endpackage

// ==== ptmr_reg_if.sv ====
`timescale 1ns/1ps
interface ptmr_reg_if;
	logic       wr_control;
	logic       wr_count;
	logic       wr_period;
	logic [7:0] wdata;
	logic [7:0] control;
	logic [7:0] period;
	logic [7:0] count;
	modport regs (output wr_control, output wr_count, output wr_period, output wdata,
		output control, output period, input count);
	modport core (input wr_control, input wr_count, input wr_period, input wdata,
		input control, input period, output count);
endinterface

// ==== ptmr_core.sv ====
`timescale 1ns/1ps
module ptmr_core
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic sleep_sync,
	ptmr_reg_if.core  rif,
	output logic      match_pulse,
	output logic      post_hit
);
	import ptmr_pkg::*;

	logic [1:0] instr_cnt_reg;
	logic       instr_tick;
	logic [5:0] ps_cnt_reg;
	logic [5:0] ps_last;
	logic       ps_tick;
	logic [3:0] post_cnt_reg;
	logic [7:0] count_reg;
	logic       match_reg;
	logic       run;
	logic       clr_scalers;

	function automatic logic [5:0] ps_decode(input logic [1:0] sel);
		case (sel)
			PS_DIV1:  ps_decode = PS_LAST_DIV1;
			PS_DIV4:  ps_decode = PS_LAST_DIV4;
			PS_DIV16: ps_decode = PS_LAST_DIV16;
			default:  ps_decode = PS_LAST_DIV64;
		endcase
	endfunction

	assign run         = rif.control[CTL_RUN_BIT] & ~sleep_sync; // [R1] [R5]
	assign clr_scalers = rif.wr_count | rif.wr_control; // [R10]
	assign ps_last     = ps_decode(rif.control[CTL_PS_LO +: 2]); // [R6]
	assign instr_tick  = (instr_cnt_reg == INSTR_DIV_LAST);
	assign ps_tick     = run & instr_tick & (ps_cnt_reg == ps_last);
	assign rif.count   = count_reg;
	assign match_pulse = match_reg;

	////////////////////////////////////////////////////////////////////////
	// instruction clock enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_cnt_reg <= 2'h0;
		end else if (!sleep_sync) begin
			instr_cnt_reg <= instr_cnt_reg + 2'h1; // [R12]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// prescaler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_cnt_reg <= 6'h00;
		end else if (clr_scalers) begin
			ps_cnt_reg <= 6'h00; // [R10]
		end else if (run && instr_tick) begin
			ps_cnt_reg <= (ps_cnt_reg == ps_last) ? 6'h00 : ps_cnt_reg + 6'h01; // [R6]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// count and compare
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= COUNT_RESET; // [R9]
		end else if (rif.wr_count) begin
			count_reg <= rif.wdata;
		end else if (ps_tick) begin
			count_reg <= (count_reg == rif.period) ? 8'h00 : count_reg + 8'h01; // [R8] [R12] [R2]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_reg <= 1'b0;
		end else begin
			match_reg <= ps_tick & ~rif.wr_count & (count_reg == rif.period); // [R8]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// postscaler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_cnt_reg <= 4'h0;
		end else if (clr_scalers) begin
			post_cnt_reg <= 4'h0; // [R10]
		end else if (match_reg) begin
			post_cnt_reg <= post_hit ? 4'h0 : post_cnt_reg + 4'h1; // [R4] [R11]
		end
	end

	assign post_hit = match_reg & ~clr_scalers
		& (post_cnt_reg == rif.control[CTL_POST_LO +: 4]); // [R4] [R11]
endmodule

// ==== ptmr_top.sv ====
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Operation
// [R1] sleep halts timer, prescaler and postscaler counting.
// [R2] count and period keep their values through sleep.
// [R3] control bit 7 reads zero, writes ignored.
// [R4] postscaler field bits 6..3, value n gives ratio 1:(n+1).
// [R5] control bit 2 runs the timer; clear stops it.
// [R6] prescale field bits 1..0 divide by 1, 4, 16, 64.
// [R7] implemented control bits reset to zero and are read/write.
// [R8] count increments from 00h; period match outputs and restarts at 00h.
// [R9] reset clears count and sets period to ffh.
// [R10] count or control write clears prescaler and postscaler, not count.
// [R11] matches feed postscaler; flag latches; request needs enable bit.
// [R12] timer input is an instruction clock enable; off holds count.
module ptmr_top
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [ptmr_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        sleep_req,
	output logic                             timer_match,
	output logic                             irq_req
);
	import ptmr_pkg::*;

	ptmr_reg_if rif ();

	logic [7:0]  control_reg;
	logic [7:0]  period_reg;
	logic        flag_reg;
	logic        enable_reg;
	logic [31:0] prdata_reg;
	logic        sleep_meta_reg;
	logic        sleep_sync_reg;
	logic        post_hit;
	logic        match_pulse;
	logic        wr;
	logic        rd;
	logic        mapped;

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = (a == OFS_CONTROL) || (a == OFS_COUNT) || (a == OFS_PERIOD)
			|| (a == OFS_FLAG) || (a == OFS_ENABLE);
	endfunction

	assign mapped  = addr_mapped(paddr);
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = prdata_reg;

	assign rif.wr_control = wr & (paddr == OFS_CONTROL);
	assign rif.wr_count   = wr & (paddr == OFS_COUNT);
	assign rif.wr_period  = wr & (paddr == OFS_PERIOD);
	assign rif.wdata      = pwdata[7:0];
	assign rif.control    = control_reg;
	assign rif.period     = period_reg;

	////////////////////////////////////////////////////////////////////////
	// sleep synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_meta_reg <= 1'b0;
			sleep_sync_reg <= 1'b0;
		end else begin
			sleep_meta_reg <= sleep_req;
			sleep_sync_reg <= sleep_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= CONTROL_RESET; // [R7]
		end else if (rif.wr_control) begin
			control_reg <= pwdata[7:0] & CTL_IMPL_MASK; // [R3] [R7]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_reg <= PERIOD_RESET; // [R9]
		end else if (rif.wr_period) begin
			period_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= 1'b0;
		end else if (post_hit) begin
			flag_reg <= 1'b1; // [R11]
		end else if (wr && paddr == OFS_FLAG) begin
			flag_reg <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= 1'b0;
		end else if (wr && paddr == OFS_ENABLE) begin
			enable_reg <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= UNMAPPED_DATA;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFS_CONTROL: prdata_reg <= {24'h000000, control_reg}; // [R3]
				OFS_COUNT:   prdata_reg <= {24'h000000, rif.count};
				OFS_PERIOD:  prdata_reg <= {24'h000000, period_reg};
				OFS_FLAG:    prdata_reg <= {31'h00000000, flag_reg};
				OFS_ENABLE:  prdata_reg <= {31'h00000000, enable_reg};
				default:     prdata_reg <= UNMAPPED_DATA;
			endcase
		end
	end

	assign irq_req     = flag_reg & enable_reg; // [R11]
	assign timer_match = match_pulse;

	////////////////////////////////////////////////////////////////////////
	// timer core
	ptmr_core u_core (
		.pclk        (pclk),
		.presetn     (presetn),
		.sleep_sync  (sleep_sync_reg),
		.rif         (rif.core),
		.match_pulse (match_pulse),
		.post_hit    (post_hit)
	);
endmodule

// ==== ptmr_props.sv ====
`timescale 1ns/1ps
module ptmr_props
(
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [ptmr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic [31:0]                 prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic                        sleep_req,
	input wire logic                        timer_match,
	input wire logic                        irq_req
);
	import ptmr_pkg::*;

	logic [7:0] ctl_sh_reg;
	logic [7:0] per_sh_reg;
	logic       en_sh_reg;
	wire        wr_acc = psel && penable && pwrite;
	wire        rd_acc = psel && penable && !pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// shadow of software-written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_sh_reg <= 8'h00;
			per_sh_reg <= 8'hff;
			en_sh_reg  <= 1'b0;
		end else if (wr_acc) begin
			if (paddr == OFS_CONTROL) ctl_sh_reg <= pwdata[7:0] & CTL_IMPL_MASK;
			if (paddr == OFS_PERIOD) per_sh_reg <= pwdata[7:0];
			if (paddr == OFS_ENABLE) en_sh_reg <= pwdata[0];
		end
	end
	////////////////////////////////////////////////////////////////
	chk_ctl_readback: assert property (rd_acc && paddr == OFS_CONTROL |->
		prdata == {24'h0, ctl_sh_reg}) else $error("control readback wrong");
	chk_ctl_msb_zero: assert property (rd_acc && paddr == OFS_CONTROL |->
		!prdata[7]) else $error("control bit 7 not zero");
	chk_period_held: assert property (rd_acc && paddr == OFS_PERIOD |->
		prdata == {24'h0, per_sh_reg}) else $error("period value changed");
	chk_irq_masked: assert property (irq_req |-> en_sh_reg)
		else $error("request without enable");
	chk_match_gap: assert property (timer_match |=> !timer_match [*3])
		else $error("matches closer than one tick");
	chk_sleep_halt: assert property (sleep_req [*8] |-> !timer_match)
		else $error("match during sleep");
	chk_off_halt: assert property (wr_acc && paddr == OFS_CONTROL &&
		!pwdata[CTL_RUN_BIT] |=> ##2 !timer_match) else $error("match while off");
	chk_reset_quiet: assert property ($rose(presetn) |->
		!timer_match && !irq_req && prdata == 32'h0) else $error("outputs after reset");
	cov_match: cover property (timer_match);
	cov_irq: cover property (irq_req);
	cov_err: cover property (pslverr);
endmodule
bind ptmr_top ptmr_props ptmr_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .timer_match(timer_match),
	.irq_req(irq_req));

// ==== ptmr_tb_top.sv ====
`timescale 1ns/1ps
module ptmr_tb_top;
	import ptmr_pkg::*;
	logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic              sleep_req = 0, pready, pslverr, timer_match, irq_req, err;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0, prdata, rdata, held;
	int                mismatches = 0, samples_checked = 0, n, g, c;
	always #12.5 pclk = ~pclk;
	ptmr_top ptmr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_req(sleep_req), .timer_match(timer_match),
		.irq_req(irq_req));
	////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] v,
		input logic [11:0] a);
		samples_checked++;
		if (v !== e) begin
			mismatches++;
			$display("MISMATCH %s at %h exp %h got %h", nm, a, e, v);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		cmp("pready", 32'h1, {31'h0, pready}, a);
		rdata = prdata;
		err   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		cmp("prdata", e, rdata, a);
	endtask
	task automatic gap;
		n = 0;
		while (timer_match !== 1'b1 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		g = 0;
		do begin
			@(posedge pclk);
			g++;
		end while (timer_match !== 1'b1 && g < 2000);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge pclk);
		mismatches++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_CONTROL, 32'(CONTROL_RESET));
		rd(OFS_COUNT, 32'(COUNT_RESET));
		rd(OFS_PERIOD, 32'(PERIOD_RESET));
		xfer(1'b1, OFS_CONTROL, 32'hff);
		rd(OFS_CONTROL, 32'h7f);
		xfer(1'b1, OFS_PERIOD, 32'h1);
		for (int k = 0; k < 4; k++) begin
			xfer(1'b1, OFS_CONTROL, 32'h4 | 32'(k));
			gap();
			cmp("match gap", 32'(8 << (2 * k)), g, OFS_CONTROL);
		end
		xfer(1'b1, OFS_ENABLE, 32'h1);
		xfer(1'b1, OFS_PERIOD, 32'h0);
		for (int p = 0; p < 16; p++) begin
			xfer(1'b1, OFS_CONTROL, 32'h0);
			xfer(1'b1, OFS_FLAG, 32'h0);
			xfer(1'b1, OFS_COUNT, 32'h0);
			xfer(1'b1, OFS_CONTROL, 32'(p << 3) | 32'h4);
			c = 0;
			n = 0;
			while (irq_req !== 1'b1 && n < 400) begin
				@(posedge pclk);
				n++;
				if (timer_match === 1'b1) c++;
			end
			cmp("match count", 32'(p + 1), c, OFS_FLAG);
		end
		xfer(1'b1, OFS_ENABLE, 32'h0);
		cmp("irq_req", 32'h0, {31'h0, irq_req}, OFS_ENABLE);
		rd(OFS_FLAG, 32'h1);
		xfer(1'b1, OFS_CONTROL, 32'h0);
		xfer(1'b1, OFS_COUNT, 32'h33);
		xfer(1'b1, OFS_CONTROL, 32'h78);
		rd(OFS_COUNT, 32'h33);
		repeat (40) @(posedge pclk);
		rd(OFS_COUNT, 32'h33);
		xfer(1'b1, OFS_PERIOD, 32'h55);
		xfer(1'b1, OFS_COUNT, 32'h0);
		xfer(1'b1, OFS_CONTROL, 32'h4);
		repeat (20) @(posedge pclk);
		sleep_req <= 1'b1;
		repeat (8) @(posedge pclk);
		xfer(1'b0, OFS_COUNT, 32'h0);
		held = rdata;
		repeat (60) @(posedge pclk);
		rd(OFS_COUNT, held);
		rd(OFS_PERIOD, 32'h55);
		sleep_req <= 1'b0;
		xfer(1'b0, 12'hffc, 32'h0);
		cmp("prdata", 32'(UNMAPPED_DATA), rdata, 12'hffc);
		cmp("pslverr", 32'h1, {31'h0, err}, 12'hffc);
		complete_run();
	end
endmodule
